// ### hdl/djr_pkg.sv
// Purpose: shared constants, types and code decoders for the pad, guard window and gain registers
// Assumes: 32-bit APB, pclk at 250 MHz, dB values in signed eighth-dB units
// Notes:   register index times four gives the APB byte address
// Notes on behaviour
// - pad bit 5 selects low or high drive
// - pad bits 3:2: up, reserved, none, down
// - window byte counts core cycles, default three
// - one window drives every guard circuit together
// - active guard stops duplicate or dropped samples
// - window zero bypasses and resets guard circuits
// - nonzero window reactivates guards without waiting
// - path disable then enable may hang guard
// - input gain: -12 dB plus 0.75 dB steps
// - noise gate: -76.5 dB plus 1.5 dB steps
// - attenuation equals code times 0.375 dB
// - attenuation slews one code step at a time
package djr_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int SMP_W  = 24;
    localparam int N_PATH = 3;
    localparam int N_CH   = 2;

    // register indices; byte address is index times four
    localparam logic [15:0] IDX_PAD     = 16'h4031;
    localparam logic [15:0] IDX_WIN     = 16'h4036;
    localparam logic [15:0] IDX_GAIN_L  = 16'h4040;
    localparam logic [15:0] IDX_GAIN_R  = 16'h4041;
    localparam logic [15:0] IDX_NGATE   = 16'h4042;
    localparam logic [15:0] IDX_ATT_L   = 16'h4043;
    localparam logic [15:0] IDX_ATT_R   = 16'h4044;
    localparam logic [15:0] IDX_STATUS  = 16'h4045;
    localparam logic [15:0] IDX_DB_GAIN = 16'h4046;
    localparam logic [15:0] IDX_DB_NG   = 16'h4047;
    localparam logic [15:0] IDX_DB_ATT  = 16'h4048;

    // field positions
    localparam int PAD_DRV_BIT   = 5;
    localparam int PAD_PULL_LSB  = 2;
    localparam int STAT_BYP_BIT  = 0;
    localparam int STAT_FAIL_LSB = 1;

    // pull selections
    localparam logic [1:0] PULL_UP   = 2'h0;
    localparam logic [1:0] PULL_RSV  = 2'h1;
    localparam logic [1:0] PULL_NONE = 2'h2;
    localparam logic [1:0] PULL_DOWN = 2'h3;

    // reset values
    localparam logic       RST_DRV   = 1'b0;
    localparam logic [1:0] RST_PULL  = PULL_NONE;
    localparam logic [7:0] RST_WIN   = 8'h03;
    localparam logic [5:0] RST_GAIN  = 6'h10;
    localparam logic [4:0] RST_NGATE = 5'h00;
    localparam logic [7:0] RST_ATT   = 8'h00;

    // decode scales in eighth-dB
    localparam logic signed [15:0] GAIN_DB_BASE = -16'sd96;
    localparam logic signed [15:0] GAIN_DB_STEP = 16'sd6;
    localparam logic signed [15:0] NG_DB_BASE   = -16'sd612;
    localparam logic signed [15:0] NG_DB_STEP   = 16'sd12;
    localparam logic signed [15:0] ATT_DB_STEP  = 16'sd3;

    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SLEW_STEP_NS  = 1000;
    localparam logic [15:0] SLEW_STEP_CYC =
        16'((SLEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {DJ_IDLE, DJ_RUN, DJ_OFF, DJ_FAIL, DJ_BYP} djr_djst_e;

    // input gain code to eighth-dB
    function automatic logic signed [15:0] djr_gain_db(input logic [5:0] c);
        return GAIN_DB_BASE + GAIN_DB_STEP * $signed({10'h000, c});
    endfunction

    // noise gate code to eighth-dB
    function automatic logic signed [15:0] djr_ng_db(input logic [4:0] c);
        return NG_DB_BASE + NG_DB_STEP * $signed({11'h000, c});
    endfunction

    // attenuation code to eighth-dB
    function automatic logic signed [15:0] djr_att_db(input logic [7:0] c);
        return -(ATT_DB_STEP * $signed({8'h00, c}));
    endfunction
endpackage

// ### hdl/djr_if.sv
// Purpose: carriers between the register top and its guard and slew units
// Assumes: one instance per path or channel
// Notes:   ctl side belongs to the top
interface djr_dj_if;
    logic [7:0]                 window;
    logic                       en;
    logic                       in_v;
    logic [djr_pkg::SMP_W-1:0]  in_d;
    logic                       tick;
    logic                       out_v;
    logic [djr_pkg::SMP_W-1:0]  out_d;
    logic                       fail;
    modport ctl (output window, en, in_v, in_d, tick, input out_v, out_d, fail);
    modport dj  (input window, en, in_v, in_d, tick, output out_v, out_d, fail);
endinterface

interface djr_sl_if;
    logic [7:0] target;
    logic [7:0] cur;
    modport ctl (output target, input cur);
    modport sl  (input target, output cur);
endinterface

// ### hdl/djr_dejit.sv
// Purpose: one sample guard circuit between a slave serial timing and the core frame tick
// Assumes: in_v pulses once per incoming sample, tick once per core frame
// Notes:   a sample late by up to window cycles still counts for the missed tick
module djr_dejit (
    input wire logic pclk,    // core clock
    input wire logic presetn, // async reset, active low
    djr_dj_if.dj     bus      // guard carrier
);
    import djr_pkg::*;

    typedef struct packed {
        djr_djst_e          st;
        logic [7:0]         cnt;
        logic               hold_v;
        logic [SMP_W-1:0]   hold_d;
        logic               out_v;
        logic [SMP_W-1:0]   out_d;
        logic               fail;
    } djr_dj_s;

    djr_dj_s r;
    djr_dj_s n;
    logic    run;

    // next state of the guard
    always_comb begin
        n = r;
        n.out_v = 1'b0;
        run = bus.en && (r.st inside {DJ_IDLE, DJ_RUN, DJ_BYP});
        if (bus.window == 8'h00) begin
            n.st     = DJ_BYP;
            n.cnt    = 8'h00;
            n.hold_v = 1'b0;
            n.out_v  = bus.in_v;
            n.out_d  = bus.in_d;
        end else begin
            unique case (r.st)
                DJ_IDLE, DJ_BYP: n.st = bus.en ? DJ_RUN : DJ_IDLE;
                DJ_RUN:  if (!bus.en) n.st = DJ_OFF;
                DJ_OFF:  if (bus.en) n.st = DJ_FAIL;
                DJ_FAIL: n.st = DJ_FAIL;
            endcase
            if (run && bus.tick) begin
                // one sample per tick: held first, fresh kept for later
                n.cnt = 8'h00;
                if (r.hold_v) begin
                    n.out_v  = 1'b1;
                    n.out_d  = r.hold_d;
                    n.hold_v = bus.in_v;
                    n.hold_d = bus.in_d;
                end else if (bus.in_v) begin
                    n.out_v = 1'b1;
                    n.out_d = bus.in_d;
                end else begin
                    n.cnt = bus.window;
                end
            end else if (run && bus.in_v) begin
                if (r.cnt != 8'h00) begin
                    n.out_v = 1'b1; // late sample fills the missed tick
                    n.out_d = bus.in_d;
                    n.cnt   = 8'h00;
                end else begin
                    n.hold_v = 1'b1;
                    n.hold_d = bus.in_d;
                end
            end else if (r.cnt != 8'h00) begin
                n.cnt = r.cnt - 8'h01;
            end
        end
        n.fail = (n.st == DJ_FAIL);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{st: DJ_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    assign bus.out_v = r.out_v;
    assign bus.out_d = r.out_d;
    assign bus.fail  = r.fail;
endmodule

// ### hdl/djr_slew.sv
// Purpose: walk the applied attenuation code toward its target one step at a time
// Assumes: step interval fixed by SLEW_STEP_CYC
// Notes:   a new target mid-walk simply redirects the walk
module djr_slew (
    input wire logic pclk,    // core clock
    input wire logic presetn, // async reset, active low
    djr_sl_if.sl     bus      // slew carrier
);
    import djr_pkg::*;

    typedef struct packed {
        logic [7:0]  cur;
        logic [15:0] tcnt;
    } djr_sl_s;

    djr_sl_s r;
    djr_sl_s n;

    // interval timer and one-step move
    always_comb begin
        n = r;
        if (r.tcnt != 16'h0000) begin
            n.tcnt = r.tcnt - 16'h0001;
        end else if (r.cur != bus.target) begin
            n.tcnt = SLEW_STEP_CYC - 16'h0001;
            n.cur  = (r.cur < bus.target) ? r.cur + 8'h01 : r.cur - 8'h01;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{cur: RST_ATT, tcnt: 16'h0000};
        end else begin
            r <= n;
        end
    end

    assign bus.cur = r.cur;
endmodule

// ### hdl/djr_top.sv
// Purpose: APB register bank for jack pad, sample guard window and gain codes
// Assumes: APB4 slave, answer one cycle after setup, all inputs synchronous to pclk
// Notes:   control registers are at most eight bits in the low byte lane, upper bits read zero; dB readbacks return 16-bit halves
//
// Implementation choice: the APB slave port.
module djr_top (
    input  wire logic                                 pclk,          // core clock
    input  wire logic                                 presetn,       // async reset, low
    input  wire logic                                 psel,          // apb select
    input  wire logic                                 penable,       // apb enable
    input  wire logic                                 pwrite,        // apb direction
    input  wire logic [djr_pkg::ADDR_W-1:0]           paddr,         // apb byte address
    input  wire logic [djr_pkg::DATA_W-1:0]           pwdata,        // apb write data
    input  wire logic [3:0]                           pstrb,         // apb byte strobes
    output wire logic [djr_pkg::DATA_W-1:0]           prdata,        // apb read data
    output wire logic                                 pready,        // apb ready
    output wire logic                                 pslverr,       // apb error
    output wire logic                                 jack_pin_drive_level,  // pad drive
    output wire logic [1:0]                           jack_pin_pull_select,  // pad pull
    output wire logic [djr_pkg::N_CH-1:0][5:0]        in_gain_code,  // input gain codes
    output wire logic [4:0]                           ngate_code,    // noise gate code
    output wire logic [djr_pkg::N_CH-1:0][7:0]        atten_cur,     // applied attenuation
    input  wire logic [djr_pkg::N_PATH-1:0]           path_en,       // adc, port, dac enable
    input  wire logic [djr_pkg::N_PATH-1:0]           smp_in_valid,  // incoming sample strobe
    input  wire logic [djr_pkg::N_PATH-1:0][djr_pkg::SMP_W-1:0] smp_in_data, // sample in
    input  wire logic [djr_pkg::N_PATH-1:0]           frame_tick,    // core frame tick
    output wire logic [djr_pkg::N_PATH-1:0]           smp_out_valid, // delivered strobe
    output wire logic [djr_pkg::N_PATH-1:0][djr_pkg::SMP_W-1:0] smp_out_data, // sample out
    output wire logic [djr_pkg::N_PATH-1:0]           guard_fail     // guard hung
);
    import djr_pkg::*;

    // software-written registers and apb answer state
    typedef struct packed {
        logic                   drv;
        logic [1:0]             pull;
        logic [7:0]             win;
        logic [N_CH-1:0][5:0]   gain;
        logic [4:0]             ngate;
        logic [N_CH-1:0][7:0]   att;
        logic [DATA_W-1:0]      prdata;
        logic                   pready;
        logic                   pslverr;
    } djr_top_s;

    djr_top_s r;
    djr_top_s n;

    // apb phase decode
    logic setup;
    logic wr_done;
    logic wr_ok;
    logic hit_any;
    logic [DATA_W-1:0] rd_val;

    // live state brought back from the units and decoded dB readbacks
    logic [N_PATH-1:0]            fail_vec;
    logic [N_CH-1:0][7:0]         cur_att;
    logic signed [15:0]           db_gain_l;
    logic signed [15:0]           db_gain_r;
    logic signed [15:0]           db_ng;
    logic signed [15:0]           db_att_l;
    logic signed [15:0]           db_att_r;

    // true when a byte address selects the given register index
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // setup cycle and completing write
    assign setup   = psel && !penable;
    assign wr_done = psel && penable && r.pready && pwrite && !r.pslverr;
    assign wr_ok   = wr_done && pstrb[0];

    // address map check
    assign hit_any = hit(paddr, IDX_PAD)     || hit(paddr, IDX_WIN)
                  || hit(paddr, IDX_GAIN_L)  || hit(paddr, IDX_GAIN_R)
                  || hit(paddr, IDX_NGATE)   || hit(paddr, IDX_ATT_L)
                  || hit(paddr, IDX_ATT_R)   || hit(paddr, IDX_STATUS)
                  || hit(paddr, IDX_DB_GAIN) || hit(paddr, IDX_DB_NG)
                  || hit(paddr, IDX_DB_ATT);

    // decoded dB readbacks
    assign db_gain_l = djr_gain_db(r.gain[0]);
    assign db_gain_r = djr_gain_db(r.gain[1]);
    assign db_ng     = djr_ng_db(r.ngate);
    assign db_att_l  = djr_att_db(cur_att[0]);
    assign db_att_r  = djr_att_db(cur_att[1]);

    // read data mux
    always_comb begin
        rd_val = '0;
        if (hit(paddr, IDX_PAD)) begin
            rd_val[PAD_DRV_BIT] = r.drv;
            rd_val[PAD_PULL_LSB +: 2] = r.pull;
        end
        if (hit(paddr, IDX_WIN)) begin
            rd_val[7:0] = r.win;
        end
        if (hit(paddr, IDX_GAIN_L)) begin
            rd_val[5:0] = r.gain[0];
        end
        if (hit(paddr, IDX_GAIN_R)) begin
            rd_val[5:0] = r.gain[1];
        end
        if (hit(paddr, IDX_NGATE)) begin
            rd_val[4:0] = r.ngate;
        end
        if (hit(paddr, IDX_ATT_L)) begin
            rd_val[7:0] = r.att[0];
        end
        if (hit(paddr, IDX_ATT_R)) begin
            rd_val[7:0] = r.att[1];
        end
        if (hit(paddr, IDX_STATUS)) begin
            rd_val[STAT_BYP_BIT] = (r.win == 8'h00);
            rd_val[STAT_FAIL_LSB +: N_PATH] = fail_vec;
        end
        if (hit(paddr, IDX_DB_GAIN)) begin
            rd_val = {db_gain_r, db_gain_l};
        end
        if (hit(paddr, IDX_DB_NG)) begin
            rd_val = {16'h0000, db_ng};
        end
        if (hit(paddr, IDX_DB_ATT)) begin
            rd_val = {db_att_r, db_att_l};
        end
    end

    // bus answer and register writes
    always_comb begin
        n = r;
        // ready rises for exactly the access cycle after setup
        n.pready  = setup;
        n.pslverr = setup && !hit_any;
        if (setup) begin
            n.prdata = (!pwrite && hit_any) ? rd_val : '0;
        end
        if (wr_ok && hit(paddr, IDX_PAD)) begin
            n.drv  = pwdata[PAD_DRV_BIT];
            n.pull = pwdata[PAD_PULL_LSB +: 2];
        end
        if (wr_ok && hit(paddr, IDX_WIN)) begin
            n.win = pwdata[7:0];
        end
        if (wr_ok && hit(paddr, IDX_GAIN_L)) begin
            n.gain[0] = pwdata[5:0];
        end
        if (wr_ok && hit(paddr, IDX_GAIN_R)) begin
            n.gain[1] = pwdata[5:0];
        end
        if (wr_ok && hit(paddr, IDX_NGATE)) begin
            n.ngate = pwdata[4:0];
        end
        if (wr_ok && hit(paddr, IDX_ATT_L)) begin
            n.att[0] = pwdata[7:0];
        end
        if (wr_ok && hit(paddr, IDX_ATT_R)) begin
            n.att[1] = pwdata[7:0];
        end
    end

    // register bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{drv:     RST_DRV,
                   pull:    RST_PULL,
                   win:     RST_WIN,
                   gain:    {RST_GAIN, RST_GAIN},
                   ngate:   RST_NGATE,
                   att:     {RST_ATT, RST_ATT},
                   prdata:  '0,
                   pready:  1'b0,
                   pslverr: 1'b0};
        end else begin
            r <= n;
        end
    end

    // one guard per path, all fed by the same window
    for (genvar i = 0; i < N_PATH; i++) begin : g_dj
        djr_dj_if u_dj_if ();

        assign u_dj_if.window = r.win;
        assign u_dj_if.en     = path_en[i];
        assign u_dj_if.in_v   = smp_in_valid[i];
        assign u_dj_if.in_d   = smp_in_data[i];
        assign u_dj_if.tick   = frame_tick[i];

        djr_dejit u_dj (
            .pclk    (pclk),
            .presetn (presetn),
            .bus     (u_dj_if)
        );

        assign smp_out_valid[i] = u_dj_if.out_v;
        assign smp_out_data[i]  = u_dj_if.out_d;
        assign fail_vec[i]      = u_dj_if.fail;
    end

    // one slew unit per attenuation channel
    for (genvar c = 0; c < N_CH; c++) begin : g_sl
        djr_sl_if u_sl_if ();

        assign u_sl_if.target = r.att[c];

        djr_slew u_sl (
            .pclk    (pclk),
            .presetn (presetn),
            .bus     (u_sl_if)
        );

        assign cur_att[c] = u_sl_if.cur;
    end

    // outputs straight from the register bank and unit flops
    assign prdata               = r.prdata;
    assign pready               = r.pready;
    assign pslverr              = r.pslverr;
    assign jack_pin_drive_level = r.drv;
    assign jack_pin_pull_select = r.pull;
    assign in_gain_code         = r.gain;
    assign ngate_code           = r.ngate;
    assign atten_cur            = cur_att;
    assign guard_fail           = fail_vec;
endmodule

// ### tb/djr_chk.sv
// Purpose: port checks for pad, guard window, bypass and slew
// Assumes: one pclk domain, presetn async active low
// Notes:   keeps a shadow of the window byte from observed writes
module djr_chk (
    input wire logic                          pclk,          // clock
    input wire logic                          presetn,       // reset
    input wire logic                          psel,          // select
    input wire logic                          penable,       // enable
    input wire logic                          pwrite,        // direction
    input wire logic [djr_pkg::ADDR_W-1:0]    paddr,         // address
    input wire logic [djr_pkg::DATA_W-1:0]    pwdata,        // write data
    input wire logic [3:0]                    pstrb,         // strobes
    input wire logic [djr_pkg::DATA_W-1:0]    prdata,        // read data
    input wire logic                          pready,        // ready
    input wire logic                          pslverr,       // error
    input wire logic                          jack_pin_drive_level, // drive
    input wire logic [1:0]                    jack_pin_pull_select, // pull
    input wire logic [djr_pkg::N_CH-1:0][7:0] atten_cur,     // attenuation
    input wire logic [djr_pkg::N_PATH-1:0]    path_en,       // path enable
    input wire logic [djr_pkg::N_PATH-1:0]    smp_in_valid,  // in strobe
    input wire logic [djr_pkg::N_PATH-1:0][djr_pkg::SMP_W-1:0] smp_in_data, // in data
    input wire logic [djr_pkg::N_PATH-1:0]    smp_out_valid, // out strobe
    input wire logic [djr_pkg::N_PATH-1:0][djr_pkg::SMP_W-1:0] smp_out_data, // out data
    input wire logic [djr_pkg::N_PATH-1:0]    guard_fail     // hung flag
);
    timeunit 1ns;
    timeprecision 1ps;
    import djr_pkg::*;
    logic       wr_pad;
    logic       wr_fire;
    logic       rd_fire;
    logic       win_zero;
    logic [7:0] win_r;
    // completed transfers
    assign wr_fire  = psel && penable && pready && pwrite && pstrb[0];
    assign rd_fire  = psel && penable && pready && !pwrite;
    assign wr_pad   = wr_fire && paddr == {IDX_PAD, 2'b00};
    assign win_zero = win_r == 8'h00;
    // shadow of the window byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            win_r <= RST_WIN;
        else if (wr_fire && paddr == {IDX_WIN, 2'b00})
            win_r <= pwdata[7:0];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_drive_write: assert property (wr_pad |=>
        jack_pin_drive_level == $past(pwdata[5]))
        else $error("drive level not taken from write");
    a_pull_write: assert property (wr_pad |=>
        jack_pin_pull_select == $past(pwdata[3:2]))
        else $error("pull select not taken from write");
    a_pad_hold: assert property (!wr_pad |=> $stable(jack_pin_pull_select))
        else $error("pull select changed without write");
    a_pad_readback: assert property (rd_fire && paddr == {IDX_PAD, 2'b00} |->
        prdata == {26'h0, jack_pin_drive_level, 1'b0, jack_pin_pull_select, 2'b00})
        else $error("pad readback wrong");
    a_win_readback: assert property (rd_fire && paddr == {IDX_WIN, 2'b00} |->
        prdata == {24'h0, win_r})
        else $error("window readback wrong");
    a_bypass_all: assert property (win_zero && (smp_in_valid & path_en) == 3'h7 |=>
        smp_out_valid == 3'h7)
        else $error("bypass not on every path");
    a_bypass_data: assert property (win_zero && smp_in_valid[0] && path_en[0] |=>
        smp_out_data[0] == $past(smp_in_data[0]))
        else $error("bypass data wrong");
    a_fail_mute: assert property (guard_fail[0] && $past(guard_fail[0]) |->
        !smp_out_valid[0])
        else $error("hung guard delivered sample");
    a_fail_clear: assert property ($fell(guard_fail[0]) |->
        win_zero || $past(win_zero))
        else $error("hung flag cleared without zero window");
    a_slew_unit: assert property ($changed(atten_cur[0]) |->
        atten_cur[0] == $past(atten_cur[0]) + 8'h01 || atten_cur[0] == $past(atten_cur[0]) - 8'h01)
        else $error("attenuation jumped");
    a_slew_space: assert property ($changed(atten_cur[0]) |=>
        $stable(atten_cur[0])[*8])
        else $error("attenuation stepped too soon");
    a_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
endmodule

// ### tb/djr_top_test.sv
// Purpose: directed register and guard tests over apb
// Assumes: answer one cycle after setup, slew step 250 cycles
// Notes:   inputs change by non-blocking assignment after rising edges
module djr_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import djr_pkg::*;
    logic                         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0]            paddr;
    logic [DATA_W-1:0]            pwdata, prdata, rd;
    logic [3:0]                   pstrb;
    logic                         jack_pin_drive_level, err;
    logic [1:0]                   jack_pin_pull_select;
    logic [N_CH-1:0][5:0]         in_gain_code;
    logic [4:0]                   ngate_code;
    logic [N_CH-1:0][7:0]         atten_cur;
    logic [N_PATH-1:0]            path_en, smp_in_valid, frame_tick, smp_out_valid, guard_fail;
    logic [N_PATH-1:0][SMP_W-1:0] smp_in_data, smp_out_data;
    logic [7:0]                   v;
    int                           bad_count, n_tests;
    djr_top u_djr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .jack_pin_drive_level, .jack_pin_pull_select,
        .in_gain_code, .ngate_code, .atten_cur, .path_en, .smp_in_valid, .smp_in_data,
        .frame_tick, .smp_out_valid, .smp_out_data, .guard_fail);
    // verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // compare and report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd,
                       input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 4'h1);
    endtask
    task automatic rdc(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, 4'h0);
        chk(rd, exp, "register read");
    endtask
    // one cycle of ticks and samples, then the delivered strobes next cycle
    task automatic sv(input logic [2:0] tm, input logic [2:0] im, input logic [23:0] d,
                      input logic [2:0] em);
        @(posedge pclk);
        frame_tick   <= tm;
        smp_in_valid <= im;
        for (int i = 0; i < N_PATH; i++)
            smp_in_data[i] <= d + 24'(i);
        @(posedge pclk);
        frame_tick   <= 3'h0;
        smp_in_valid <= 3'h0;
        @(negedge pclk);
        chk({29'h0, smp_out_valid}, {29'h0, em}, "out strobe");
        for (int i = 0; i < N_PATH; i++)
            if (em[i])
                chk({8'h0, smp_out_data[i]}, {8'h0, d + 24'(i)}, "out data");
    endtask
    // clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    // watchdog
    initial begin
        #80000;
        bad_count++;
        tally_and_finish();
    end
    // test sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        {frame_tick, smp_in_valid, smp_in_data} = '0;
        path_en = 3'h7;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(IDX_PAD, 32'h08);
        rdc(IDX_WIN, 32'h03);
        chk({29'h0, jack_pin_drive_level, jack_pin_pull_select}, 32'h2, "pad pins");
        $display("test reset done");
        for (int k = 0; k < 8; k++) begin
            v = 8'hd3 | (k[0] ? 8'h20 : 8'h00) | {4'h0, 2'(k >> 1), 2'b00};
            wr(IDX_PAD, {24'h0, v});
            rdc(IDX_PAD, {24'h0, v & 8'h2c});
            chk({29'h0, jack_pin_drive_level, jack_pin_pull_select},
                {29'h0, v[5], v[3:2]}, "pad pins");
        end
        apb(1'b1, IDX_PAD, 32'h0, 4'h0);
        rdc(IDX_PAD, 32'h2c);
        $display("test pad done");
        wr(IDX_WIN, 32'h05);
        rdc(IDX_WIN, 32'h05);
        apb(1'b1, 16'h4039, 32'h0, 4'h1);
        chk({31'h0, err}, 32'h1, "unmapped error");
        wr(IDX_WIN, 32'h00);
        rdc(IDX_STATUS, 32'h1);
        sv(3'h0, 3'h7, 24'h1234a0, 3'h7);
        $display("test bypass done");
        wr(IDX_WIN, 32'h03);
        sv(3'h7, 3'h0, 24'h0, 3'h0);
        sv(3'h0, 3'h7, 24'h00beef, 3'h7);
        repeat (8) @(posedge pclk);
        sv(3'h0, 3'h2, 24'h000100, 3'h0);
        sv(3'h0, 3'h2, 24'h000200, 3'h0);
        sv(3'h2, 3'h0, 24'h000200, 3'h2);
        $display("test guard done");
        @(posedge pclk);
        path_en <= 3'h6;
        @(posedge pclk);
        path_en <= 3'h7;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk({29'h0, guard_fail}, 32'h1, "hung flag");
        sv(3'h1, 3'h1, 24'h000300, 3'h0);
        rdc(IDX_STATUS, 32'h2);
        wr(IDX_WIN, 32'h00);
        wr(IDX_WIN, 32'h03);
        @(negedge pclk);
        chk({29'h0, guard_fail}, 32'h0, "hung flag");
        sv(3'h1, 3'h0, 24'h0, 3'h0);
        sv(3'h0, 3'h1, 24'h000400, 3'h1);
        $display("test failure done");
        wr(IDX_GAIN_R, 32'h3f);
        for (int k = 0; k < 3; k++) begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'h10 : 8'h3f;
            wr(IDX_GAIN_L, {24'h0, v});
            @(negedge pclk);
            chk({26'h0, in_gain_code[0]}, {24'h0, v}, "gain code");
            rdc(IDX_DB_GAIN, {16'h011a, 16'(-96 + 6 * int'(v))});
        end
        wr(IDX_NGATE, 32'h1f);
        apb(1'b0, IDX_DB_NG, 32'h0, 4'h0);
        chk({16'h0, rd[15:0]}, {16'h0, 16'(-612 + 12 * 31)}, "gate level");
        chk({27'h0, ngate_code}, 32'h1f, "gate code");
        $display("test gain done");
        wr(IDX_ATT_L, 32'h02);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk({24'h0, atten_cur[0]}, 32'h1, "first slew step");
        repeat (SLEW_STEP_CYC - 2) @(posedge pclk);
        @(negedge pclk);
        chk({24'h0, atten_cur[0]}, 32'h1, "slew hold");
        @(negedge pclk);
        chk({16'h0, atten_cur}, 32'h0002, "second slew step");
        rdc(IDX_DB_ATT, 32'h0000fffa);
        $display("test slew done");
        tally_and_finish();
    end
endmodule

bind djr_top djr_chk u_djr_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .jack_pin_drive_level, .jack_pin_pull_select,
    .atten_cur, .path_en, .smp_in_valid, .smp_in_data, .smp_out_valid, .smp_out_data,
    .guard_fail);
